// >>> core/sres_pkg.sv
// Shared constants and carrier types for the serial receive-error status block
package sres_pkg;
    // ========================================================================
    // Clock and register map
    // ========================================================================
    localparam int unsigned CLK_HZ     = 40_000_000; // Peripheral clock rate
    localparam int unsigned ADDR_W     = 8;          // Byte address width
    localparam logic [7:0]  OFS_STATUS = 8'h00;      // Serial status
    localparam logic [7:0]  OFS_CTRL   = 8'h04;      // Control / format
    localparam logic [7:0]  OFS_RXDATA = 8'h08;      // Receive data (read)
    localparam logic [7:0]  OFS_TXDATA = 8'h0c;      // Transmit data (write)
    localparam logic [7:0]  OFS_IRQ_ST = 8'h10;      // Sticky event status (read)
    localparam logic [7:0]  OFS_IRQ_CL = 8'h14;      // Event clear (write 1)
    localparam logic [7:0]  OFS_IRQ_EN = 8'h18;      // Event enable

    // ========================================================================
    // Serial status fields
    // ========================================================================
    localparam int unsigned BIT_TXE    = 7;          // Transmit empty flag
    localparam int unsigned BIT_RXF    = 6;          // Receive full flag
    localparam int unsigned BIT_OVR    = 5;          // Overrun flag
    localparam int unsigned BIT_FRM    = 4;          // Framing error flag
    localparam int unsigned BIT_PAR    = 3;          // Parity error flag
    localparam int unsigned BIT_TRANSMIT_END_FLAG   = 2;          // Transmit end flag
    localparam logic [7:0]  STATUS_RST = 8'h84;      // Reset / standby value
    localparam logic [7:0]  CLR_MASK   = 8'hf8;      // Bits software may clear

    // ========================================================================
    // Control fields
    // ========================================================================
    localparam int unsigned CTL_W      = 6;
    localparam int unsigned CTL_RE     = 0;          // Receive enable
    localparam int unsigned CTL_TE     = 1;          // Transmit enable
    localparam int unsigned CTL_SYNC   = 2;          // 1: clocked synchronous
    localparam int unsigned CTL_PEN    = 3;          // Parity present
    localparam int unsigned CTL_ODD    = 4;          // 1: odd parity
    localparam int unsigned CTL_STOP2  = 5;          // Two stop bits
    localparam logic [5:0]  CTL_RST    = 6'h00;

    // ========================================================================
    // Interrupt event fields
    // ========================================================================
    localparam int unsigned IRQ_W      = 5;
    localparam int unsigned IRQ_RXF    = 0;
    localparam int unsigned IRQ_OVR    = 1;
    localparam int unsigned IRQ_FRM    = 2;
    localparam int unsigned IRQ_PAR    = 3;
    localparam int unsigned IRQ_TRANSMIT_END_FLAG   = 4;

    // Received character as it leaves the shift-register datapath
    typedef struct packed {
        logic [7:0] data;    // Data bits
        logic       parity;  // Sampled parity bit
        logic       stop1;   // First stop bit
        logic       stop2;   // Second stop bit (never checked)
    } sres_rx_char_s;

    // Error verdict for one character
    typedef struct packed {
        logic frm;
        logic par;
    } sres_rx_err_s;
endpackage

// >>> core/sres_rx_check.sv
// Stop-bit and parity check of one completed receive character
`timescale 1ns/1ps
`default_nettype none
module sres_rx_check
    import sres_pkg::*;
(
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    input  wire logic          i_done,   // Character complete (pulse)
    input  wire sres_rx_char_s i_char,   // Character fields
    input  wire logic          i_sync,   // Synchronous mode
    input  wire logic          i_pen,    // Parity enabled
    input  wire logic          i_odd,    // Odd parity selected
    output sres_rx_err_s       o_err     // Verdict, combinational
);
    // ========================================================================
    // Parity helper
    // ========================================================================
    // Xor of all ones in data and parity bit
    function automatic logic ones_odd(input logic [7:0] d, input logic p);
        ones_odd = (^d) ^ p;
    endfunction

    wire logic odd_ones = ones_odd(i_char.data, i_char.parity);

    // Errors exist only in asynchronous mode
    // Only the first stop bit counts; stop2 is ignored
    assign o_err.frm = ~i_sync & ~i_char.stop1;
    // Even parity wants an even count of ones, odd wants odd
    assign o_err.par = ~i_sync & i_pen & (odd_ones != i_odd);

    // ========================================================================
    // Checks
    // ========================================================================
    AST_SYNC_NO_ERR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_done && i_sync |-> !o_err.frm && !o_err.par)
        else $error("error reported in synchronous mode");
    AST_FRM_STOP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_done && !i_sync && i_char.stop1 |-> !o_err.frm)
        else $error("framing error with good first stop bit");
endmodule
`default_nettype wire

// >>> core/sres_irq.sv
// Sticky event status, enable mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module sres_irq #(
    parameter int unsigned W = 5
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_event,    // Event pulses
    input  wire logic         i_clr_wr,   // Clear register written
    input  wire logic         i_en_wr,    // Enable register written
    input  wire logic [W-1:0] i_wdata,    // Write data
    output logic      [W-1:0] o_status,   // Sticky bits
    output logic      [W-1:0] o_enable,   // Enable mask
    output logic              o_irq       // Level interrupt
);
    logic [W-1:0] status_reg;
    logic [W-1:0] enable_reg;
    // Set wins over a clear in the same cycle so no event is lost
    wire logic [W-1:0] status_next =
        (status_reg & ~(i_clr_wr ? i_wdata : '0)) | i_event;

    // Sticky status and mask
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status_reg <= '0;
            enable_reg <= '0;
        end else begin
            status_reg <= status_next;
            if (i_en_wr) begin
                enable_reg <= i_wdata;
            end
        end
    end

    assign o_status = status_reg;
    assign o_enable = enable_reg;
    assign o_irq    = |(status_reg & enable_reg);

    // Every pulsed event bit must be held, even against a clear in the same cycle
    AST_IRQ_STICKY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        |i_event |=> (status_reg & $past(i_event)) == $past(i_event))
        else $error("event not captured");
    // The interrupt may only rise after an event or an enable write
    AST_IRQ_LEVEL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_irq) |-> $past(|i_event) || $past(i_en_wr))
        else $error("interrupt rose without cause");
endmodule
`default_nettype wire

// >>> core/sres_top.sv
// Serial receive-error and transmit-end status block with APB registers
// Notes on behaviour
// - Receive disabled leaves error flags untouched
// - Errors clear on reset, standby, read-then-zero
// - Overrun when character ends with receive full
// - Overrun keeps old byte, drops new one
// - Errors halt receive; sync mode halts transmit
// - Framing and parity checked only asynchronously
// - Zero first stop bit sets framing error
// - Second stop bit never checked
// - Framing/parity error loads data, not full flag
// - Ones count mismatch with parity sets error
// - Transmit end: last bit sent, data empty
// - Transmit end flag is read-only
// - Only zero writes clear, after reading set
// - Eight-bit status, resets to 0x84
// - Transmit end set/cleared by listed events
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sres_top
    import sres_pkg::*;
(
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    // APB slave
    input  wire logic          i_psel,
    input  wire logic          i_penable,
    input  wire logic          i_pwrite,
    input  wire logic [7:0]    i_paddr,
    input  wire logic [31:0]   i_pwdata,
    output logic               o_pready,
    output logic               o_pslverr,
    output logic      [31:0]   o_prdata,
    // Power state
    input  wire logic          i_standby,     // Standby entry (level)
    // Receive datapath
    input  wire logic          i_rx_done,     // Character complete (pulse)
    input  wire sres_rx_char_s i_rx_char,
    output logic               o_rx_halt,     // Reception must stop
    // Transmit datapath
    input  wire logic          i_tx_load,     // Transmit data taken (pulse)
    input  wire logic          i_tx_last_bit, // Last bit sent (pulse)
    output logic      [7:0]    o_tx_data,
    output logic               o_tx_valid,    // Transmit data waiting
    output logic               o_tx_halt,     // Transmission must stop
    // Interrupt
    output logic               o_irq
);
    // ========================================================================
    // APB decode
    // ========================================================================
    wire logic setup  = i_psel & ~i_penable;
    wire logic access = i_psel & i_penable;
    wire logic wr_acc = access & i_pwrite;
    wire logic rd_acc = access & ~i_pwrite;
    wire logic sel_st = i_paddr == OFS_STATUS;
    wire logic sel_ct = i_paddr == OFS_CTRL;
    wire logic sel_rx = i_paddr == OFS_RXDATA;
    wire logic sel_tx = i_paddr == OFS_TXDATA;
    wire logic sel_is = i_paddr == OFS_IRQ_ST;
    wire logic sel_ic = i_paddr == OFS_IRQ_CL;
    wire logic sel_ie = i_paddr == OFS_IRQ_EN;
    wire logic mapped = sel_st | sel_ct | sel_rx | sel_tx | sel_is | sel_ic | sel_ie;

    // ========================================================================
    // State
    // ========================================================================
    logic [7:0]       status_reg;  // Serial status
    logic [7:0]       status_next;
    logic [7:0]       armed_reg;   // Flags read while set
    logic [7:0]       armed_next;
    logic [CTL_W-1:0] ctrl_reg;    // Control / format
    logic [7:0]       rdr_reg;     // Receive data register
    logic [7:0]       tdr_reg;     // Transmit data register
    logic [31:0]      prdata_reg;  // Read data captured in setup
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    sres_rx_err_s     rx_err;

    wire logic re_on   = ctrl_reg[CTL_RE];
    wire logic te_on   = ctrl_reg[CTL_TE];
    wire logic sync_md = ctrl_reg[CTL_SYNC];
    wire logic any_err = status_reg[BIT_OVR] | status_reg[BIT_FRM] | status_reg[BIT_PAR];

    // ========================================================================
    // Character checker
    // ========================================================================
    sres_rx_check u_check (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_done  (i_rx_done),
        .i_char  (i_rx_char),
        .i_sync  (sync_md),
        .i_pen   (ctrl_reg[CTL_PEN]),
        .i_odd   (ctrl_reg[CTL_ODD]),
        .o_err   (rx_err)
    );

    // ========================================================================
    // Receive events
    // ========================================================================
    // Disabled or halted receiver ignores completions, flags hold
    wire logic rx_take = i_rx_done & re_on & ~any_err;
    // Overrun wins over a framing or parity verdict on the same character
    wire logic ev_ovr  = rx_take & status_reg[BIT_RXF];
    wire logic ev_bad  = rx_take & ~status_reg[BIT_RXF] & (rx_err.frm | rx_err.par);
    wire logic ev_good = rx_take & ~status_reg[BIT_RXF] & ~rx_err.frm & ~rx_err.par;
    // Data loads on good or bad characters, never on overrun
    wire logic rdr_ld  = ev_good | ev_bad;
    // Transmit end when last bit leaves and nothing is waiting
    wire logic ev_transmit_end_flag = i_tx_last_bit & status_reg[BIT_TXE];

    // ========================================================================
    // Software clears
    // ========================================================================
    // Zero bits of a status write clear only armed flags; ones do nothing
    wire logic [7:0] wclr  = (wr_acc & sel_st) ? (~i_pwdata[7:0] & armed_reg & CLR_MASK)
                                               : 8'h00;
    wire logic       rd_st = rd_acc & sel_st;
    wire logic       rd_rx = rd_acc & sel_rx;
    wire logic       wr_tx = wr_acc & sel_tx;

    // Next status: clears first, then sets so that a set wins over a clear; standby overrides both
    always_comb begin
        status_next = status_reg & ~wclr;
        // Reading the empty flag then clearing it also ends transmit end
        if (wclr[BIT_TXE]) begin
            status_next[BIT_TRANSMIT_END_FLAG] = 1'b0;
        end
        // Reading receive data empties the register
        if (rd_rx) begin
            status_next[BIT_RXF] = 1'b0;
        end
        // Writing transmit data makes it valid and ends transmit end
        if (wr_tx) begin
            status_next[BIT_TXE]  = 1'b0;
            status_next[BIT_TRANSMIT_END_FLAG] = 1'b0;
        end
        if (i_tx_load) begin
            status_next[BIT_TXE] = 1'b1;
        end
        // A disabled transmitter reports empty and ended
        if (!te_on) begin
            status_next[BIT_TXE]  = 1'b1;
            status_next[BIT_TRANSMIT_END_FLAG] = 1'b1;
        end
        if (ev_transmit_end_flag) begin
            status_next[BIT_TRANSMIT_END_FLAG] = 1'b1;
        end
        // All character verdicts land in this same cycle
        if (ev_good) begin
            status_next[BIT_RXF] = 1'b1;
        end
        if (ev_ovr) begin
            status_next[BIT_OVR] = 1'b1;
        end
        if (ev_bad && rx_err.frm) begin
            status_next[BIT_FRM] = 1'b1;
        end
        if (ev_bad && rx_err.par) begin
            status_next[BIT_PAR] = 1'b1;
        end
        // Standby puts the register back to its reset value
        if (i_standby) begin
            status_next = STATUS_RST;
        end
        status_next[1:0] = 2'b00;                         // Unused bits read zero
    end

    // Arming: a read of a set flag permits its later clear; any clear attempt,
    // or the flag dropping, disarms so a fresh set must be read again
    wire logic [7:0] rd_arm = rd_st ? (prdata_reg[7:0] & CLR_MASK) : 8'h00;
    assign armed_next = i_standby ? 8'h00 : ((armed_reg | rd_arm) & ~wclr & status_next);

    // ========================================================================
    // Registers
    // ========================================================================
    // Status and arming
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status_reg <= STATUS_RST;
            armed_reg  <= 8'h00;
        end else begin
            status_reg <= status_next;
            armed_reg  <= armed_next;
        end
    end

    // Control, written whole; transmit end has no write path
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= CTL_RST;
        end else if (wr_acc && sel_ct) begin
            ctrl_reg <= i_pwdata[CTL_W-1:0];
        end
    end

    // Data registers; overrun leaves the old byte in place
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdr_reg <= 8'h00;
            tdr_reg <= 8'h00;
        end else begin
            if (rdr_ld) begin
                rdr_reg <= i_rx_char.data;
            end
            if (wr_tx) begin
                tdr_reg <= i_pwdata[7:0];
            end
        end
    end

    // ========================================================================
    // Read path: data captured in setup so the answer comes from a flop
    // ========================================================================
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (1'b1)
            sel_st:  rd_mux[7:0]       = status_reg;
            sel_ct:  rd_mux[CTL_W-1:0] = ctrl_reg;
            sel_rx:  rd_mux[7:0]       = rdr_reg;
            sel_is:  rd_mux[IRQ_W-1:0] = irq_status;
            sel_ie:  rd_mux[IRQ_W-1:0] = irq_enable;
            default: rd_mux            = 32'h0000_0000;  // Write-only or unmapped
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup && !i_pwrite) begin
            prdata_reg <= rd_mux;
        end
    end

    // Zero wait states; unmapped addresses answer with an error
    assign o_pready  = 1'b1;
    assign o_pslverr = access & ~mapped;
    assign o_prdata  = prdata_reg;

    // ========================================================================
    // Datapath controls
    // ========================================================================
    // Halt reception on any error; sync mode also halts transmission
    assign o_rx_halt  = any_err | ~re_on;
    assign o_tx_halt  = (sync_md & any_err) | ~te_on;
    assign o_tx_data  = tdr_reg;
    assign o_tx_valid = ~status_reg[BIT_TXE];

    // ========================================================================
    // Interrupts
    // ========================================================================
    wire logic [IRQ_W-1:0] irq_ev = {ev_transmit_end_flag, ev_bad & rx_err.par,
                                     ev_bad & rx_err.frm, ev_ovr, ev_good};

    sres_irq #(.W(IRQ_W)) u_irq (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_event  (irq_ev),
        .i_clr_wr (wr_acc & sel_ic),
        .i_en_wr  (wr_acc & sel_ie),
        .i_wdata  (i_pwdata[IRQ_W-1:0]),
        .o_status (irq_status),
        .o_enable (irq_enable),
        .o_irq    (o_irq)
    );

    // ========================================================================
    // Checks
    // ========================================================================
    AST_RE_OFF_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !re_on && !i_standby && !(wr_acc && sel_st) |=>
        status_reg[5:3] == $past(status_reg[5:3]))
        else $error("error flags moved while receive disabled");
    AST_OVR_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rx_done && re_on && !any_err && status_reg[BIT_RXF] && !i_standby
        |=> status_reg[BIT_OVR])
        else $error("overrun not flagged");
    AST_OVR_KEEP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ev_ovr |=> rdr_reg == $past(rdr_reg))
        else $error("overrun replaced receive data");
    AST_HALT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        any_err |-> o_rx_halt && (o_tx_halt || !sync_md))
        else $error("datapath not halted on error");
    AST_BAD_LOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ev_bad && !i_standby |=> rdr_reg == $past(i_rx_char.data) && !status_reg[BIT_RXF])
        else $error("bad character handling wrong");
    AST_WRITE_ONE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_acc && sel_st && (i_pwdata[5:3] == 3'b111) && !i_standby && !rd_rx
        |=> status_reg[5:3] == ($past(status_reg[5:3]) | status_reg[5:3]) &&
            ($past(status_reg[5:3]) & ~status_reg[5:3]) == 3'b000)
        else $error("write of one cleared a flag");
    AST_UNARMED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_acc && sel_st && !armed_reg[BIT_OVR] && status_reg[BIT_OVR] && !i_standby
        |=> status_reg[BIT_OVR])
        else $error("unread overrun flag cleared");
    AST_STANDBY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_standby |=> status_reg == STATUS_RST)
        else $error("standby value wrong");
    AST_TRANSMIT_END_FLAG: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ev_transmit_end_flag && !wr_tx && !i_standby ##1 !wclr[BIT_TXE] |-> status_reg[BIT_TRANSMIT_END_FLAG])
        else $error("transmit end not set");
    AST_TE_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !te_on |=> status_reg[BIT_TRANSMIT_END_FLAG] && status_reg[BIT_TXE])
        else $error("transmitter off without end flag");
endmodule
`default_nettype wire

// >>> dv/sres_station.sv
// Remote station model: received characters and transmit pulses
`timescale 1ns/1ps
`default_nettype none
module sres_station
    import sres_pkg::*;
(
    input  wire logic     i_clk,
    output sres_rx_char_s o_char,
    output logic          o_done,
    output logic          o_tx_load,
    output logic          o_tx_last
);
    // ======================================================
    // Idle levels
    // ======================================================
    initial begin
        o_char = '0;
        o_done = 1'b0;
        o_tx_load = 1'b0;
        o_tx_last = 1'b0;
    end
    // Fields are valid only with the completion pulse
    task automatic rx(input logic [7:0] d, input logic p, input logic s1, input logic s2);
        @(posedge i_clk);
        o_done <= 1'b1;
        o_char <= {d, p, s1, s2};
        @(posedge i_clk);
        o_done <= 1'b0;
        o_char <= ~o_char; // Stale fields must never look valid
        @(negedge i_clk);
    endtask
    // One-cycle transmit pulses
    task automatic tx(input logic ld, input logic lb);
        @(posedge i_clk);
        o_tx_load <= ld;
        o_tx_last <= lb;
        @(posedge i_clk);
        o_tx_load <= 1'b0;
        o_tx_last <= 1'b0;
        @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// >>> dv/sres_top_tb.sv
// Self-checking bench for the serial receive-error status block
`timescale 1ns/1ps
`default_nettype none
module sres_top_tb
    import sres_pkg::*;
;
    // ======================================================
    // Signals
    // ======================================================
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, stby = 0;
    logic [7:0] paddr = '0, d, txd;
    logic [31:0] pwdata = '0, prdata, r;
    logic done, load, last, rdy, err, slv, rxh, txh, txv, irq, odd, bad, s1;
    sres_rx_char_s ch;
    int n_mismatch = 0, comparisons = 0;
    always #12.5 clk = ~clk;
    sres_station rs (.i_clk(clk), .o_char(ch), .o_done(done), .o_tx_load(load),
        .o_tx_last(last));
    sres_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(rdy),
        .o_pslverr(err), .o_prdata(prdata), .i_standby(stby), .i_rx_done(done),
        .i_rx_char(ch), .o_rx_halt(rxh), .i_tx_load(load), .i_tx_last_bit(last),
        .o_tx_data(txd), .o_tx_valid(txv), .o_tx_halt(txh), .o_irq(irq));
    // ======================================================
    // Tasks
    // ======================================================
    // APB transfer; ends at negedge so outputs are settled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, v};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        r = prdata;
        slv = err;
        {psel, pen} <= 2'b00;
        @(negedge clk);
    endtask
    task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, x, g);
        end
    endtask
    task automatic st(input logic [7:0] x);
        apb(1'b0, OFS_STATUS, 32'h0);
        cmp("status", {24'h0, x}, r);
    endtask
    // Status after one async character with parity on
    function automatic logic [7:0] rx_exp(input logic s, input logic b);
        return 8'h84 | (s ? 8'h00 : 8'h10) | (b ? 8'h08 : 8'h00) | ((s && !b) ? 8'h40 : 8'h00);
    endfunction
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ======================================================
    // Sequence
    // ======================================================
    initial begin
        d = 8'($urandom(47089));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        st(8'h84);
        apb(1'b1, OFS_CTRL, 32'h0b);
        rs.rx(8'h3c, 1'b0, 1'b1, 1'b1);
        st(8'hc4);
        apb(1'b0, OFS_RXDATA, 32'h0);
        // Overrun: second byte lands while the first is unread
        rs.rx(8'h11, 1'b0, 1'b1, 1'b1);
        rs.rx(8'h22, 1'b0, 1'b1, 1'b1);
        cmp("rx_halt", 32'h1, {31'h0, rxh});
        apb(1'b1, OFS_CTRL, 32'h0a);
        rs.rx(8'h33, 1'b0, 1'b1, 1'b1);
        apb(1'b0, OFS_RXDATA, 32'h0);
        cmp("rxdata", 32'h11, r);
        apb(1'b1, OFS_STATUS, 32'hdf);
        st(8'ha4);
        apb(1'b1, OFS_STATUS, 32'hdf);
        st(8'h84);
        // Random characters, stop and parity faults mixed in
        for (int i = 0; i < 12; i++) begin
            odd = i[0];
            d = 8'($urandom);
            bad = 1'($urandom_range(1));
            s1 = (i < 4) ? i[0] : 1'($urandom_range(1));
            apb(1'b1, OFS_CTRL, {26'h0, i[1], odd, 4'hb});
            rs.rx(d, ^d ^ odd ^ bad, s1, i[0] ^ i[1]);
            st(rx_exp(s1, bad));
            apb(1'b0, OFS_RXDATA, 32'h0);
            cmp("rxdata", {24'h0, d}, r);
            apb(1'b1, OFS_STATUS, 32'he7);
        end
        // Synchronous mode: no stop or parity checks
        apb(1'b1, OFS_CTRL, 32'h0f);
        rs.rx(8'h5a, 1'b1, 1'b0, 1'b0);
        rs.rx(8'h5a, 1'b1, 1'b0, 1'b0);
        st(8'he4);
        cmp("tx_halt", 32'h1, {31'h0, txh});
        apb(1'b0, OFS_RXDATA, 32'h0);
        apb(1'b1, OFS_STATUS, 32'hdf);
        apb(1'b1, OFS_CTRL, 32'h0b);
        // Transmit end
        apb(1'b1, OFS_TXDATA, 32'ha5);
        st(8'h00);
        cmp("tx_data", 32'h1a5, {23'h0, txv, txd});
        rs.tx(1'b0, 1'b1);
        st(8'h00);
        rs.tx(1'b1, 1'b0);
        rs.tx(1'b0, 1'b1);
        apb(1'b1, OFS_STATUS, 32'hfb);
        st(8'h84);
        apb(1'b1, OFS_TXDATA, 32'h0f);
        @(posedge clk);
        stby <= 1'b1;
        @(posedge clk);
        stby <= 1'b0;
        st(8'h84);
        // Interrupt mask and clear, unmapped access
        apb(1'b1, OFS_IRQ_EN, 32'h00);
        cmp("irq", 32'h0, {31'h0, irq});
        apb(1'b1, OFS_IRQ_EN, 32'h1f);
        cmp("irq", 32'h1, {31'h0, irq});
        apb(1'b1, OFS_IRQ_CL, 32'h1f);
        cmp("irq", 32'h0, {31'h0, irq});
        apb(1'b0, OFS_IRQ_ST, 32'h0);
        cmp("irq_status", 32'h0, r);
        apb(1'b0, 8'h1c, 32'h0);
        cmp("unmapped", 32'h1, {31'h0, slv});
        close_out();
    end
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #100000;
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
